// [rtl/cise_pkg.sv]
// Purpose: constants and types for the instruction subset execution block
// Assumes: 14-bit instruction words, 8-bit data, 128 file registers
// Notes: opcode patterns are compared under a mask; register port indices are byte addresses
// Summary of operation
// [RL1] increment_skip_if_zero adds one to file register f (0..127), result to W for d=0 or f for d=1, no flag changes.
// [RL2] if that result is zero the following instruction is replaced by a no_operation, costing two instruction cycles.
// [RL3] unconditional_jump loads its 11-bit operand into pc[10:0] and latch bits [4:3] into pc[12:11].
// [RL4] unconditional_jump takes two instruction cycles and leaves every flag unchanged.
// [RL5] or_literal_into_accumulator ORs W with an 8-bit literal into W and updates the zero flag.
// [RL6] increment_file adds one to file register f, result to W for d=0 or f for d=1, and updates the zero flag.
// [RL7] or_accumulator_with_file ORs W with file register f, result to W for d=0 or f for d=1, updates zero flag.
// [RL8] move_file copies f to W for d=0 or onto itself for d=1, updates the zero flag, one word and one cycle.
// [RL9] whenever the zero flag is updated it is set for a zero 8-bit result and cleared otherwise.
package cise_pkg;
	localparam int unsigned CISE_IR_W    = 14;
	localparam int unsigned CISE_PC_W    = 13;
	localparam int unsigned CISE_DATA_W  = 8;
	localparam int unsigned CISE_FADDR_W = 7;
	localparam int unsigned CISE_BUS_AW  = 8;
	localparam int unsigned CISE_JUMP_W  = 11;

	// opcode pattern and mask pairs
	localparam logic [13:0] CISE_OP_INC_SKIP   = 14'h0F00;
	localparam logic [13:0] CISE_OP_INCREMENT_FILE       = 14'h0A00;
	localparam logic [13:0] CISE_OP_OR_ACCUMULATOR_WITH_FILE      = 14'h0400;
	localparam logic [13:0] CISE_OP_MOVE_FILE       = 14'h0800;
	localparam logic [13:0] CISE_OP_OR_LITERAL_INTO_ACCUMULATOR      = 14'h3800;
	localparam logic [13:0] CISE_OP_JUMP       = 14'h2800;
	localparam logic [13:0] CISE_OP_NOP        = 14'h0000;
	localparam logic [13:0] CISE_MASK_FILE     = 14'h3F00;
	localparam logic [13:0] CISE_MASK_JUMP     = 14'h3800;

	localparam int unsigned CISE_D_BIT         = 7;
	localparam int unsigned CISE_LATCH_HI      = 4;
	localparam int unsigned CISE_LATCH_LO      = 3;
	localparam int unsigned CISE_Z_BIT         = 0;
	localparam int unsigned CISE_MEM_SEL_BIT   = 7;

	// register port map; addresses below 8'h80 write the file registers
	localparam logic [7:0] CISE_REG_LATCH      = 8'h80;
	localparam logic [7:0] CISE_REG_ACC        = 8'h81;
	localparam logic [7:0] CISE_REG_STATUS     = 8'h82;
	localparam logic [7:0] CISE_REG_PC_LO      = 8'h83;
	localparam logic [7:0] CISE_REG_PC_HI      = 8'h84;

	localparam logic [7:0]  CISE_ACC_RST       = 8'h00;
	localparam logic [7:0]  CISE_LATCH_RST     = 8'h00;
	localparam logic [12:0] CISE_PC_RST        = 13'h0000;
	localparam logic [12:0] CISE_PC_ONE        = 13'h0001;
	localparam logic [7:0]  CISE_DATA_ONE      = 8'h01;

	typedef enum logic [1:0] {CISE_FETCH, CISE_READ, CISE_EXEC} cise_state_t;
endpackage

// [rtl/cise_mem_if.sv]
// Purpose: carries the two ports of the file register memory
// Assumes: port a belongs to the execution core, port b to the register port
// Notes: port b is write only
`timescale 1ns/10ps
`default_nettype none
interface cise_mem_if #(parameter int unsigned AW = 7, parameter int unsigned DW = 8);
	logic [AW-1:0] a_addr;
	logic          a_we;
	logic [DW-1:0] a_wdata;
	logic [DW-1:0] a_rdata;
	logic [AW-1:0] b_addr;
	logic          b_we;
	logic [DW-1:0] b_wdata;

	modport ctl (output a_addr, output a_we, output a_wdata, input a_rdata,
		output b_addr, output b_we, output b_wdata);
	modport mem (input a_addr, input a_we, input a_wdata, output a_rdata,
		input b_addr, input b_we, input b_wdata);
endinterface
`default_nettype wire

// [rtl/cise_file_mem.sv]
// Purpose: 128-byte file register array with a registered read port
// Assumes: read data for an address appear one clock after it is presented
// Notes: on a same-address collision the core write wins over the register port
`timescale 1ns/10ps
`default_nettype none
module cise_file_mem
	import cise_pkg::*;
#(
	parameter int unsigned AW = 7,
	parameter int unsigned DW = 8
) (
	input wire logic clk,
	input wire logic rst,
	cise_mem_if.mem  m
);
	logic [DW-1:0] store_q [2**AW];

	// array left without reset so it maps onto plain RAM
	always_ff @(posedge clk) begin
		if (m.b_we && !(m.a_we && (m.a_addr == m.b_addr))) begin
			store_q[m.b_addr] <= m.b_wdata;
		end
		if (m.a_we) begin
			store_q[m.a_addr] <= m.a_wdata;
		end
	end

	logic [DW-1:0] rdata_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= store_q[m.a_addr];
		end
	end
	assign m.a_rdata = rdata_q;
endmodule // cise_file_mem
`default_nettype wire

// [rtl/cise_core.sv]
// Purpose: executes a subset of 8-bit core instructions against W, Z, pc and file registers
// Assumes: instr is valid from same-clock logic, paired with fetch_addr while instr_ready is high
// Notes: one instruction cycle is three clocks: fetch, read, execute
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cise_core
	import cise_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    instr_valid,
	input  wire logic [CISE_IR_W-1:0]    instr,
	output var  logic                    instr_ready,
	output var  logic [CISE_PC_W-1:0]    fetch_addr,
	input  wire logic [CISE_BUS_AW-1:0]  reg_addr,
	input  wire logic [CISE_DATA_W-1:0]  reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [CISE_DATA_W-1:0]  reg_rdata
);
	function automatic logic op_is(input logic [CISE_IR_W-1:0] ir,
		input logic [CISE_IR_W-1:0] code, input logic [CISE_IR_W-1:0] mask);
		op_is = ((ir & mask) == code);
	endfunction

	cise_mem_if #(.AW(CISE_FADDR_W), .DW(CISE_DATA_W)) mif ();

	cise_file_mem #(.AW(CISE_FADDR_W), .DW(CISE_DATA_W)) u_mem (
		.clk (clk),
		.rst (rst),
		.m   (mif.mem)
	);

	cise_state_t                state_q;
	cise_state_t                state_d;
	logic [CISE_IR_W-1:0]       ir_q;
	logic [CISE_PC_W-1:0]       pc_q;
	logic [CISE_DATA_W-1:0]     w_q;
	logic                       z_q;
	logic [CISE_DATA_W-1:0]     latch_q;
	logic                       skip_q;
	logic                       bubble_q;
	logic                       bubble_d;
	logic                       ready_q;
	logic [CISE_DATA_W-1:0]     rdata_q;

	logic                       take;
	logic                       exec;
	logic                       dest_f;
	logic [CISE_DATA_W-1:0]     fval;
	logic                       is_inc_skip;
	logic                       is_increment_file;
	logic                       is_or_accumulator_with_file;
	logic                       is_move_file;
	logic                       is_or_literal_into_accumulator;
	logic                       is_jump;
	logic [CISE_DATA_W-1:0]     res;
	logic                       writes_res;
	logic                       upd_z;
	logic [CISE_PC_W-1:0]       jump_target;

	assign take   = (state_q == CISE_FETCH) && ready_q && instr_valid;
	assign exec   = (state_q == CISE_EXEC);
	assign dest_f = ir_q[CISE_D_BIT];
	assign fval   = mif.a_rdata;

	assign is_inc_skip = op_is(ir_q, CISE_OP_INC_SKIP, CISE_MASK_FILE);
	assign is_increment_file     = op_is(ir_q, CISE_OP_INCREMENT_FILE, CISE_MASK_FILE);
	assign is_or_accumulator_with_file    = op_is(ir_q, CISE_OP_OR_ACCUMULATOR_WITH_FILE, CISE_MASK_FILE);
	assign is_move_file     = op_is(ir_q, CISE_OP_MOVE_FILE, CISE_MASK_FILE);
	assign is_or_literal_into_accumulator    = op_is(ir_q, CISE_OP_OR_LITERAL_INTO_ACCUMULATOR, CISE_MASK_FILE);
	assign is_jump     = op_is(ir_q, CISE_OP_JUMP, CISE_MASK_JUMP);

	assign jump_target = {latch_q[CISE_LATCH_HI:CISE_LATCH_LO],
		ir_q[CISE_JUMP_W-1:0]}; // [RL3]

	// result and destination; unsupported codes fall through as no_operation
	always_comb begin
		res        = '0;
		writes_res = 1'b0;
		upd_z      = 1'b0;
		if (is_inc_skip) begin
			res        = fval + CISE_DATA_ONE; // [RL1]
			writes_res = 1'b1;
		end else if (is_increment_file) begin
			res        = fval + CISE_DATA_ONE; // [RL6]
			writes_res = 1'b1;
			upd_z      = 1'b1;
		end else if (is_or_accumulator_with_file) begin
			res        = w_q | fval; // [RL7]
			writes_res = 1'b1;
			upd_z      = 1'b1;
		end else if (is_move_file) begin
			res        = fval; // [RL8]
			writes_res = 1'b1;
			upd_z      = 1'b1;
		end else if (is_or_literal_into_accumulator) begin
			res        = w_q | ir_q[CISE_DATA_W-1:0]; // [RL5]
			upd_z      = 1'b1;
		end
	end

	// core owns port a; register port owns port b
	assign mif.a_addr  = ir_q[CISE_FADDR_W-1:0];
	assign mif.a_we    = exec && writes_res && dest_f; // [RL1] [RL6] [RL7] [RL8]
	assign mif.a_wdata = res;
	assign mif.b_addr  = reg_addr[CISE_FADDR_W-1:0];
	assign mif.b_we    = reg_wr && !reg_addr[CISE_MEM_SEL_BIT];
	assign mif.b_wdata = reg_wdata;

	always_comb begin
		state_d  = state_q;
		bubble_d = bubble_q;
		unique case (state_q)
			CISE_FETCH: begin
				if (bubble_q || take) begin
					state_d  = CISE_READ;
					bubble_d = 1'b0;
				end
			end
			CISE_READ: state_d = CISE_EXEC;
			CISE_EXEC: begin
				state_d  = CISE_FETCH;
				bubble_d = is_jump; // [RL4]
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q  <= CISE_FETCH;
			bubble_q <= 1'b0;
			ready_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			bubble_q <= bubble_d;
			// the second cycle of a jump fetches nothing
			ready_q  <= (state_d == CISE_FETCH) && !bubble_d; // [RL4]
		end
	end

	// a squashed fetch still consumes its slot, keeping skip timing exact
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ir_q   <= CISE_OP_NOP;
			skip_q <= 1'b0;
		end else if (state_q == CISE_FETCH && bubble_q) begin
			ir_q <= CISE_OP_NOP; // [RL4]
		end else if (take) begin
			ir_q   <= skip_q ? CISE_OP_NOP : instr; // [RL2]
			skip_q <= 1'b0;
		end else if (exec && is_inc_skip && (res == '0)) begin
			skip_q <= 1'b1; // [RL2]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_q <= CISE_PC_RST;
		end else if (exec && is_jump) begin
			pc_q <= jump_target; // [RL3]
		end else if (take) begin
			pc_q <= pc_q + CISE_PC_ONE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_q <= CISE_ACC_RST;
		end else if (exec && (is_or_literal_into_accumulator || (writes_res && !dest_f))) begin
			w_q <= res; // [RL1] [RL5] [RL6] [RL7] [RL8]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			z_q <= 1'b0;
		end else if (exec && upd_z) begin
			z_q <= (res == '0); // [RL9]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q <= CISE_LATCH_RST;
		end else if (reg_wr && reg_addr == CISE_REG_LATCH) begin
			latch_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				CISE_REG_LATCH:  rdata_q <= latch_q;
				CISE_REG_ACC:    rdata_q <= w_q;
				CISE_REG_STATUS: rdata_q <= {{(CISE_DATA_W-1){1'b0}}, z_q};
				CISE_REG_PC_LO:  rdata_q <= pc_q[7:0];
				CISE_REG_PC_HI:  rdata_q <= {3'h0, pc_q[12:8]};
				default:         rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign instr_ready = ready_q;
	assign fetch_addr  = pc_q;
	assign reg_rdata   = rdata_q;

	// clocks spent with instr_ready low; a jump is the longest stall the rules allow
	localparam logic [2:0] CISE_STALL_MAX = 3'h5;
	logic [2:0]                 wait_cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_cnt_q <= 3'h0;
		end else if (ready_q) begin
			wait_cnt_q <= 3'h0;
		end else if (wait_cnt_q != 3'h7) begin
			// saturates so that a hang cannot wrap back into the legal range
			wait_cnt_q <= wait_cnt_q + 3'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_skip_hit;
		exec && is_inc_skip && (res == '0);
	endsequence
	// the pending skip waits in skip_q for the next take, so no long wait is unrolled
	sequence s_squash_take;
		skip_q && take;
	endsequence

	a_skip_armed: assert property ( // [RL2]
		s_skip_hit |=> skip_q && ready_q)
		else $error("zero skip result did not arm the squash");
	a_skip_squash: assert property ( // [RL2]
		s_squash_take |=> ir_q == CISE_OP_NOP && !skip_q)
		else $error("instruction after a zero skip result was not squashed");
	a_skip_noskip: assert property ( // [RL2]
		(exec && is_inc_skip && res != '0 && !skip_q) |=> !skip_q)
		else $error("nonzero increment result caused a skip");
	a_incskip_flags: assert property ( // [RL1]
		(exec && is_inc_skip) |=> $stable(z_q))
		else $error("zero flag moved on increment with skip");
	a_incskip_dest: assert property ( // [RL1]
		(exec && is_inc_skip && !dest_f) |=> w_q == $past(fval) + CISE_DATA_ONE)
		else $error("increment with skip result not in W");
	a_jump_target: assert property ( // [RL3]
		(exec && is_jump) |=> pc_q == {$past(latch_q[4:3]), $past(ir_q[10:0])})
		else $error("jump target wrong");
	a_jump_two_cycles: assert property ( // [RL4]
		(exec && is_jump) |=> (!instr_ready && $stable(z_q) && $stable(w_q))[*3]
			##1 instr_ready)
		else $error("jump did not take exactly two instruction cycles");
	a_orlit_result: assert property ( // [RL5]
		(exec && is_or_literal_into_accumulator) |=> w_q == ($past(w_q) | $past(ir_q[7:0])) && z_q == (w_q == '0))
		else $error("or literal result or zero flag wrong");
	a_increment_file_route: assert property ( // [RL6]
		(exec && is_increment_file) |-> (dest_f ? (mif.a_we && mif.a_wdata == fval + CISE_DATA_ONE)
			: !mif.a_we))
		else $error("increment destination wrong");
	a_or_accumulator_with_file_route: assert property ( // [RL7]
		(exec && is_or_accumulator_with_file && !dest_f) |=> w_q == ($past(w_q) | $past(fval)))
		else $error("or with file result not in W");
	a_move_file_copy: assert property ( // [RL8]
		(exec && is_move_file) |=> (dest_f ? $stable(w_q) : w_q == $past(fval))
			&& z_q == ($past(fval) == '0))
		else $error("move file copy or flag wrong");
	a_zero_flag: assert property ( // [RL9]
		(exec && upd_z) |=> z_q == ($past(res) == '0))
		else $error("zero flag does not match result");

	// file writes, sequencing and stall length
	a_stall_bound: assert property ( // [RL4]
		wait_cnt_q <= CISE_STALL_MAX)
		else $error("instruction port stalled longer than a jump");
	a_ready_fetch: assert property ( // [RL4]
		instr_ready |-> state_q == CISE_FETCH && !bubble_q)
		else $error("ready raised outside a fetch slot");
	a_jump_no_write: assert property ( // [RL4]
		(exec && is_jump) |-> !mif.a_we)
		else $error("jump wrote a file register");
	a_pc_advance: assert property ( // [RL2]
		take |=> pc_q == $past(pc_q) + CISE_PC_ONE)
		else $error("program counter did not advance on a take");
	a_move_file_cycle: assert property ( // [RL8]
		(exec && is_move_file) |=> instr_ready)
		else $error("move file took more than one instruction cycle");
	a_incskip_file: assert property ( // [RL1]
		(exec && is_inc_skip && dest_f) |-> mif.a_we && mif.a_wdata == fval + CISE_DATA_ONE)
		else $error("increment with skip result not written to file");
	a_or_accumulator_with_file_file: assert property ( // [RL7]
		(exec && is_or_accumulator_with_file && dest_f) |-> mif.a_we && mif.a_wdata == (w_q | fval))
		else $error("or with file result not written to file");
	a_move_file_file: assert property ( // [RL8]
		(exec && is_move_file && dest_f) |-> mif.a_we && mif.a_wdata == fval)
		else $error("move file did not write the file back");
	a_orlit_no_mem: assert property ( // [RL5]
		(exec && is_or_literal_into_accumulator) |-> !mif.a_we)
		else $error("or literal wrote a file register");
endmodule // cise_core
`default_nettype wire

// [verif/core_instr_subset_exec_tb_top.sv]
// Purpose: self-checking bench for the instruction subset execution core
// Assumes: file registers are only visible by moving them into the accumulator
// Notes: one task per scenario; expected values are tracked by hand in each task
`timescale 1ns/10ps
`default_nettype none
module core_instr_subset_exec_tb_top;
	import cise_pkg::*;
	localparam logic [13:0] op_inc = 14'h0A00;
	localparam logic [13:0] op_orf = 14'h0400;
	localparam logic [13:0] op_mov = 14'h0800;
	localparam logic [13:0] op_orl = 14'h3800;
	logic                   clk;
	logic                   rst;
	logic                   instr_valid;
	logic [CISE_IR_W-1:0]   instr;
	logic                   instr_ready;
	logic [CISE_PC_W-1:0]   fetch_addr;
	logic [CISE_PC_W-1:0]   pc_e;
	logic [7:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [7:0]             reg_rdata;
	int                     failures;
	int                     n_tests;
	int                     cyc;
	int                     n;

	cise_core u_dut (
		.clk         (clk),
		.rst         (rst),
		.instr_valid (instr_valid),
		.instr       (instr),
		.instr_ready (instr_ready),
		.fetch_addr  (fetch_addr),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// all scenarios together need well under a thousand clocks
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			$display("[FAIL] run did not finish in time");
			print_verdict();
		end
	end

	function automatic logic [13:0] fop(input logic [13:0] op, input logic d,
		input logic [6:0] f);
		return op | {6'h00, d, f};
	endfunction

	task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk(what, {5'h00, reg_rdata}, {5'h00, exp});
	endtask

	// strobe is lowered and an edge passes, so a following write never reassigns it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// n counts clocks from the take edge until the core is ready again
	task automatic issue(input logic [13:0] w);
		instr <= w;
		instr_valid <= 1'b1;
		@(posedge clk);
		while (instr_ready !== 1'b1) @(posedge clk);
		instr_valid <= 1'b0;
		pc_e = pc_e + 13'h0001;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (instr_ready !== 1'b1);
	endtask

	task automatic wz(input logic [7:0] w, input logic z);
		rdchk(CISE_REG_ACC, w, "accumulator");
		rdchk(CISE_REG_STATUS, {7'h00, z}, "zero flag");
	endtask

	task automatic t_reset();
		rdchk(CISE_REG_ACC, 8'h00, "acc reset");
		rdchk(CISE_REG_STATUS, 8'h00, "status reset");
		rdchk(CISE_REG_LATCH, 8'h00, "latch reset");
		rdchk(CISE_REG_PC_LO, 8'h00, "pc low reset");
		rdchk(CISE_REG_PC_HI, 8'h00, "pc high reset");
		wr(CISE_REG_LATCH, 8'hE7);
		rdchk(CISE_REG_LATCH, 8'hE7, "latch rw");
		wr(CISE_REG_ACC, 8'h55);
		rdchk(CISE_REG_ACC, 8'h00, "acc read only");
		wr(8'h05, 8'hFF);
		rdchk(8'h05, 8'h00, "file read");
		rdchk(8'hF0, 8'h00, "unmapped read");
		$display("test reset done");
	endtask

	task automatic t_inc();
		wr(8'h06, 8'h41);
		wr(8'h07, 8'h00);
		issue(fop(op_inc, 1'b0, 7'h05));
		wz(8'h00, 1'b1);
		issue(fop(op_inc, 1'b1, 7'h06));
		wz(8'h00, 1'b0);
		issue(fop(op_mov, 1'b0, 7'h06));
		chk("move cycles", 13'(n), 13'h0003);
		wz(8'h42, 1'b0);
		issue(fop(op_mov, 1'b1, 7'h07));
		wz(8'h42, 1'b1);
		issue(fop(op_mov, 1'b0, 7'h05));
		wz(8'hFF, 1'b0);
		$display("test increment done");
	endtask

	task automatic t_or();
		issue(fop(op_mov, 1'b0, 7'h07));
		issue(op_orl | 14'h0000);
		wz(8'h00, 1'b1);
		issue(op_orl | 14'h00A5);
		wz(8'hA5, 1'b0);
		wr(8'h10, 8'h5A);
		issue(fop(op_orf, 1'b1, 7'h10));
		wz(8'hA5, 1'b0);
		issue(fop(op_mov, 1'b0, 7'h10));
		wz(8'hFF, 1'b0);
		issue(fop(op_mov, 1'b0, 7'h07));
		issue(fop(op_orf, 1'b0, 7'h10));
		wz(8'hFF, 1'b0);
		$display("test or done");
	endtask

	task automatic t_skip();
		wr(8'h20, 8'hFE);
		issue(fop(op_mov, 1'b0, 7'h07));
		issue(fop(CISE_OP_INC_SKIP, 1'b1, 7'h20));
		wz(8'h00, 1'b1);
		issue(op_orl | 14'h0001);
		wz(8'h01, 1'b0);
		issue(fop(CISE_OP_INC_SKIP, 1'b0, 7'h20));
		wz(8'h00, 1'b0);
		issue(op_orl | 14'h0080);
		chk("skipped cycles", 13'(n), 13'h0003);
		wz(8'h00, 1'b0);
		chk("pc after skip", fetch_addr, pc_e);
		issue(fop(op_mov, 1'b0, 7'h20));
		wz(8'hFF, 1'b0);
		$display("test skip done");
	endtask

	task automatic jmp(input logic [7:0] latch, input logic [10:0] k, input logic z);
		wr(CISE_REG_LATCH, latch);
		issue(CISE_OP_JUMP | {3'h0, k});
		pc_e = {latch[4:3], k};
		chk("jump cycles", 13'(n), 13'h0006);
		chk("jump target", fetch_addr, pc_e);
		rdchk(CISE_REG_PC_LO, pc_e[7:0], "pc low");
		rdchk(CISE_REG_PC_HI, {3'h0, pc_e[12:8]}, "pc high");
		rdchk(CISE_REG_STATUS, {7'h00, z}, "flag kept");
	endtask

	task automatic t_jump();
		jmp(8'h18, 11'h7FF, 1'b0);
		issue(fop(op_mov, 1'b0, 7'h07));
		jmp(8'hE7, 11'h123, 1'b1);
		jmp(8'h08, 11'h400, 1'b1);
		$display("test jump done");
	endtask

	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		failures = 0;
		n_tests = 0;
		cyc = 0;
		pc_e = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_inc();
		t_or();
		t_skip();
		t_jump();
		print_verdict();
	end
endmodule // core_instr_subset_exec_tb_top
`default_nettype wire
